// File: hdl/xirq_pkg.sv
// package for the shared interrupt vector multiplexer and trap prioritiser
package xirq_pkg;
  localparam int NUM_VEC = 4;
  localparam int NUM_SRC = 8;
  localparam int REG_W = 16;
  localparam int EN_LSB = 8;
  localparam int ADDR_W = 4;
  // word indexes on the register bus
  localparam logic [ADDR_W-1:0] ADR_SEL0 = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_TRAP_FLAG = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_TRAP_STATE = 4'h7;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  // source routing: bit n of a vector mask = source position n may be used
  // pos: 0 first_can_controller 1 second_can_controller 2 rx 3 tx 4 txbuf 5 err 6 pll/osc wd 7 pwm
  localparam logic [7:0] ROUTE_V0 = 8'h1D;
  localparam logic [7:0] ROUTE_V1 = 8'h1E;
  localparam logic [7:0] ROUTE_V2 = 8'h9C;
  localparam logic [7:0] ROUTE_V3 = 8'hE3;
  localparam logic [31:0] ROUTE_ALL = {ROUTE_V3, ROUTE_V2, ROUTE_V1, ROUTE_V0};
  // trap vectors and numbers
  localparam logic [23:0] VEC_RESET = 24'h000000;
  localparam logic [23:0] VEC_NMI = 24'h000008;
  localparam logic [23:0] VEC_STKOV = 24'h000010;
  localparam logic [23:0] VEC_STKUN = 24'h000018;
  localparam logic [23:0] VEC_CLASS_B = 24'h000028;
  localparam logic [6:0] TN_RESET = 7'h00;
  localparam logic [6:0] TN_NMI = 7'h02;
  localparam logic [6:0] TN_STKOV = 7'h04;
  localparam logic [6:0] TN_STKUN = 7'h06;
  localparam logic [6:0] TN_CLASS_B = 7'h0A;
  localparam logic [3:0] PRIO_MAX = 4'hF;
  localparam int VEC_SHIFT = 2;
  // trap flag positions
  localparam int TF_NMI = 15;
  localparam int TF_STKOV = 14;
  localparam int TF_STKUN = 13;
  localparam int TF_BUS = 7;
  localparam int TF_MAC = 6;
  localparam int TF_INSTR = 3;
  localparam int TF_OPND = 2;
  localparam int TF_PROT = 1;
  localparam int TF_OPC = 0;
  typedef enum logic [1:0] {EXC_NONE, EXC_RESET, EXC_CLASS_A, EXC_CLASS_B} xirq_class_t;
  typedef struct packed {
    logic nmi;
    logic stk_over;
    logic stk_under;
    logic bad_opcode;
    logic mac_fault;
    logic protected_instr;
    logic bad_operand;
    logic bad_instr_access;
    logic bad_extbus;
  } xirq_traps_t;
  typedef struct packed {
    logic [23:0] vector;
    logic [6:0] number;
    logic [3:0] prio;
  } xirq_branch_t;
endpackage

// File: hdl/xirq_mux.sv
// shared expansion interrupt vectors, trap flags and trap prioritiser
`timescale 1ns/100ps
// Contract
// - four shared vectors, each with its own 16-bit select register.
// - select bits 15..8 are per-source enables.
// - select bits 7..0 are per-source event flags.
// - a vector requests only for flagged sources whose enable is set.
// - flags record events even when the enable bit is clear.
// - can one routes to vectors 0 and 3, can two to 1 and 3.
// - serial rx/tx events route to vectors 0-2, errors to vector 3.
// - pll/oscillator watchdog only to vector 3; pwm to vectors 2 and 3.
// - resets use vector 000000h, number 00h, highest priority.
// - class A traps own vectors, numbers 02h, 04h, 06h, second priority.
// - class B traps share vector 000028h, below class A and resets.
// - software trap number 00h-7Fh, vector number times four, current priority.
// - priority level forced to 15 while servicing resets or hardware traps.
// - every hardware trap sets its own trap flag bit.
// - hardware trap service blocks standard interrupts and event transfers.
module xirq_mux
  import xirq_pkg::*;
#(
  parameter int N_VEC = NUM_VEC
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic [ADDR_W-1:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  input wire logic [3:0] I_BYTEENABLE,
  output logic [31:0] O_READDATA,
  output logic O_WAITREQUEST,
  input wire logic [NUM_SRC-1:0] I_SRC_EVENT,
  input wire xirq_traps_t I_TRAP,
  input wire logic I_RESET_EVENT,
  input wire logic I_SW_TRAP,
  input wire logic [6:0] I_SW_TRAP_NUM,
  input wire logic [3:0] I_CPU_PRIO,
  input wire logic I_SERVICE_DONE,
  output logic [NUM_VEC-1:0] O_SHARED_VEC,
  output logic O_BRANCH,
  output xirq_branch_t O_BRANCH_INFO,
  output logic O_BLOCK_STD,
  output logic O_IRQ
);
  logic [REG_W-1:0] sel_q [N_VEC];
  logic [15:0] trap_flag_q;
  logic [15:0] stat_q;
  logic [15:0] mask_q;
  xirq_class_t svc_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [NUM_VEC-1:0] vec_q;
  logic branch_q;
  xirq_branch_t info_q;
  logic irq_q;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] wdata;
  logic [15:0] trap_set;
  logic [15:0] stat_set;
  xirq_class_t req_cls;
  xirq_branch_t req_info;
  logic take;

  // one wait cycle per access, then the answer
  assign wr_acc = I_WRITE && ack_q;
  assign rd_acc = I_READ && ack_q;
  assign wdata = I_WRITEDATA[15:0] & {{8{I_BYTEENABLE[1]}}, {8{I_BYTEENABLE[0]}}};

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= (I_READ || I_WRITE) && !ack_q;
      wait_q <= !((I_READ || I_WRITE) && !ack_q);
    end
  end
  assign O_WAITREQUEST = wait_q;

  genvar v;
  generate
    for (v = 0; v < N_VEC; v++) begin : g_vec
      localparam logic [7:0] ROUTE = ROUTE_ALL[v*8 +: 8];
      always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          sel_q[v] <= SEL_RESET;
        end else if (wr_acc && I_ADDRESS == ADR_SEL0 + ADDR_W'(v)) begin
          // writing a flag to zero clears it; a same-cycle event still sets it
          sel_q[v][15:EN_LSB] <= wdata[15:EN_LSB] & ROUTE;
          sel_q[v][EN_LSB-1:0] <= (wdata[EN_LSB-1:0] & sel_q[v][EN_LSB-1:0])
            | (I_SRC_EVENT & ROUTE);
        end else begin
          sel_q[v][EN_LSB-1:0] <= sel_q[v][EN_LSB-1:0] | (I_SRC_EVENT & ROUTE);
        end
      end
      always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          vec_q[v] <= 1'b0;
        end else begin
          vec_q[v] <= |(sel_q[v][15:EN_LSB] & sel_q[v][EN_LSB-1:0]);
        end
      end
    end
  endgenerate

  assign O_SHARED_VEC = vec_q;
  always_comb begin
    trap_set = '0;
    trap_set[TF_NMI] = I_TRAP.nmi;
    trap_set[TF_STKOV] = I_TRAP.stk_over;
    trap_set[TF_STKUN] = I_TRAP.stk_under;
    trap_set[TF_OPC] = I_TRAP.bad_opcode;
    trap_set[TF_MAC] = I_TRAP.mac_fault;
    trap_set[TF_PROT] = I_TRAP.protected_instr;
    trap_set[TF_OPND] = I_TRAP.bad_operand;
    trap_set[TF_INSTR] = I_TRAP.bad_instr_access;
    trap_set[TF_BUS] = I_TRAP.bad_extbus;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      trap_flag_q <= '0;
    end else if (wr_acc && I_ADDRESS == ADR_TRAP_FLAG) begin
      trap_flag_q <= (trap_flag_q & wdata) | trap_set;
    end else begin
      trap_flag_q <= trap_flag_q | trap_set;
    end
  end

  // priority: resets, then class A in order, then class B, then software
  always_comb begin
    req_cls = EXC_NONE;
    req_info = '{vector: VEC_RESET, number: TN_RESET, prio: I_CPU_PRIO};
    if (I_RESET_EVENT) begin
      req_cls = EXC_RESET;
      req_info = '{vector: VEC_RESET, number: TN_RESET, prio: PRIO_MAX};
    end else if (I_TRAP.nmi) begin
      req_cls = EXC_CLASS_A;
      req_info = '{vector: VEC_NMI, number: TN_NMI, prio: PRIO_MAX};
    end else if (I_TRAP.stk_over) begin
      req_cls = EXC_CLASS_A;
      req_info = '{vector: VEC_STKOV, number: TN_STKOV, prio: PRIO_MAX};
    end else if (I_TRAP.stk_under) begin
      req_cls = EXC_CLASS_A;
      req_info = '{vector: VEC_STKUN, number: TN_STKUN, prio: PRIO_MAX};
    end else if (|trap_set[TF_BUS:TF_OPC]) begin
      req_cls = EXC_CLASS_B;
      req_info = '{vector: VEC_CLASS_B, number: TN_CLASS_B, prio: PRIO_MAX};
    end else if (I_SW_TRAP) begin
      req_info.vector = 24'({I_SW_TRAP_NUM, VEC_SHIFT'(0)});
      req_info.number = I_SW_TRAP_NUM;
      req_info.prio = I_CPU_PRIO;
    end
  end

  // a lower or equal class cannot break into a running trap service
  always_comb begin
    case (svc_q)
      EXC_NONE: take = (req_cls != EXC_NONE) || I_SW_TRAP;
      EXC_CLASS_B: take = (req_cls == EXC_RESET) || (req_cls == EXC_CLASS_A);
      EXC_CLASS_A: take = (req_cls == EXC_RESET);
      EXC_RESET: take = 1'b0;
      default: take = 1'b0;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      svc_q <= EXC_NONE;
    end else if (take && req_cls != EXC_NONE) begin
      svc_q <= req_cls;
    end else if (I_SERVICE_DONE) begin
      svc_q <= EXC_NONE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      branch_q <= 1'b0;
      info_q <= '0;
    end else begin
      branch_q <= take;
      if (take) begin
        info_q <= req_info;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_BLOCK_STD <= 1'b0;
    end else begin
      O_BLOCK_STD <= (svc_q != EXC_NONE) || (take && req_cls != EXC_NONE);
    end
  end

  assign O_BRANCH = branch_q;
  assign O_BRANCH_INFO = info_q;

  // block status: bits 3..0 shared vector requests, bit 4 reset or hardware trap taken
  always_comb begin
    stat_set = '0;
    stat_set[NUM_VEC-1:0] = vec_q & ~stat_q[NUM_VEC-1:0];
    stat_set[NUM_VEC] = take && req_cls != EXC_NONE;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      stat_q <= '0;
    end else if (wr_acc && I_ADDRESS == ADR_IRQ_STAT) begin
      stat_q <= (stat_q & ~wdata) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mask_q <= '0;
    end else if (wr_acc && I_ADDRESS == ADR_IRQ_MASK) begin
      mask_q <= (mask_q & ~{{8{I_BYTEENABLE[1]}}, {8{I_BYTEENABLE[0]}}}) | wdata;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign O_IRQ = irq_q;

  // unmapped addresses read zero
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_q <= '0;
    end else if (I_READ && !ack_q) begin
      rdata_q <= '0;
      if (I_ADDRESS < ADR_SEL0 + ADDR_W'(N_VEC)) begin
        rdata_q <= {16'h0000, sel_q[I_ADDRESS[1:0]]};
      end else if (I_ADDRESS == ADR_TRAP_FLAG) begin
        rdata_q <= {16'h0000, trap_flag_q};
      end else if (I_ADDRESS == ADR_IRQ_STAT) begin
        rdata_q <= {16'h0000, stat_q};
      end else if (I_ADDRESS == ADR_IRQ_MASK) begin
        rdata_q <= {16'h0000, mask_q};
      end else if (I_ADDRESS == ADR_TRAP_STATE) begin
        rdata_q <= {30'h0000000, svc_q};
      end
    end
  end

  assign O_READDATA = rdata_q;

  // assertions
  vec_follow_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    vec_q[0] == $past(|(sel_q[0][15:8] & sel_q[0][7:0])))
    else $error("shared vector 0 does not follow enabled flags");
  route_v1_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (sel_q[1] & {~ROUTE_V1, ~ROUTE_V1}) == 16'h0000)
    else $error("vector 1 holds an unroutable source");
  route_v3_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (sel_q[3] & {~ROUTE_V3, ~ROUTE_V3}) == 16'h0000)
    else $error("vector 3 holds an unroutable source");
  route_v2_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (sel_q[2][7:0] & 8'h23) == 8'h00)
    else $error("vector 2 holds can or error source");
  flag_set_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_SRC_EVENT[2] |=> sel_q[0][2])
    else $error("masked rx event was not recorded");
  flag_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    sel_q[3][0] && !(wr_acc && I_ADDRESS == 4'h3) |=> sel_q[3][0])
    else $error("flag dropped without a write");
  trap_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_TRAP.stk_over |=> trap_flag_q[TF_STKOV])
    else $error("stack overflow flag not set");
  reset_prio_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_RESET_EVENT && svc_q != EXC_RESET |=> O_BRANCH && O_BRANCH_INFO.vector == 24'h000000
      && O_BRANCH_INFO.prio == 4'hF)
    else $error("reset did not branch to vector zero at level 15");
  nmi_vec_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_TRAP.nmi && !I_RESET_EVENT && svc_q == EXC_NONE |=> O_BRANCH_INFO.number == 7'h02)
    else $error("nmi trap number wrong");
  class_b_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    req_cls == EXC_CLASS_B |-> req_info.vector == 24'h000028 && req_info.prio == 4'hF)
    else $error("class b branch wrong");
  sw_trap_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_SW_TRAP && req_cls == EXC_NONE && svc_q == EXC_NONE
      |=> O_BRANCH_INFO.vector == {15'h0000, $past(I_SW_TRAP_NUM), 2'b00}
      && O_BRANCH_INFO.prio == $past(I_CPU_PRIO))
    else $error("software trap vector or level wrong");
  block_std_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    svc_q != EXC_NONE |=> O_BLOCK_STD)
    else $error("standard interrupts not blocked in trap service");
  cover_shared: cover property (@(posedge I_CLK) disable iff (!I_RSTN) O_SHARED_VEC[3]);
  cover_nest: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
    svc_q == EXC_CLASS_B ##1 svc_q == EXC_CLASS_A);
  cover_clear_race: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
    wr_acc && I_ADDRESS == ADR_SEL0 && |I_SRC_EVENT);
  cover_irq: cover property (@(posedge I_CLK) disable iff (!I_RSTN) O_IRQ);
endmodule // xirq_mux

// File: test/xirq_far_end.sv
// far-side model: peripheral event sources and cpu trap side
`timescale 1ns/100ps
module xirq_far_end
  import xirq_pkg::*;
(
  input wire logic i_clk,
  output logic [NUM_SRC-1:0] o_src_event,
  output xirq_traps_t o_trap,
  output logic o_reset_event,
  output logic o_sw_trap,
  output logic [6:0] o_sw_trap_num,
  output logic [3:0] o_cpu_prio,
  output logic o_service_done
);
  initial begin
    o_src_event = '0;
    o_trap = '0;
    o_reset_event = 1'b0;
    o_sw_trap = 1'b0;
    o_sw_trap_num = 7'h00;
    o_cpu_prio = 4'h0;
    o_service_done = 1'b0;
  end
  // one-cycle pulses so each event is counted once; number and priority stay put
  task automatic pulse(input logic [7:0] s, input logic [8:0] t, input logic r,
                       input logic sw, input logic [6:0] n, input logic [3:0] p,
                       input logic dn);
    @(posedge i_clk);
    o_src_event <= s;
    o_trap <= t;
    o_reset_event <= r;
    o_sw_trap <= sw;
    o_sw_trap_num <= n;
    o_cpu_prio <= p;
    o_service_done <= dn;
    @(posedge i_clk);
    o_src_event <= '0;
    o_trap <= '0;
    o_reset_event <= 1'b0;
    o_sw_trap <= 1'b0;
    o_service_done <= 1'b0;
  endtask
endmodule // xirq_far_end

// File: test/tb_xbus_irq_mux_and_traps.sv
// self-checking bench for the shared vector multiplexer and trap prioritiser
`timescale 1ns/100ps
module tb_xbus_irq_mux_and_traps
  import xirq_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic wreq;
  logic [7:0] src;
  xirq_traps_t trap;
  logic rst_ev, sw, done;
  logic [6:0] swn;
  logic [3:0] prio;
  logic [3:0] vec;
  logic br, blk, irq;
  xirq_branch_t binfo;
  int miscompares = 0;
  int num_checks = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  xirq_far_end far (.i_clk(clk), .o_src_event(src), .o_trap(trap), .o_reset_event(rst_ev),
    .o_sw_trap(sw), .o_sw_trap_num(swn), .o_cpu_prio(prio), .o_service_done(done));
  xirq_mux uut (.I_CLK(clk), .I_RSTN(rstn), .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr),
    .I_WRITEDATA(wdat), .I_BYTEENABLE(4'h3), .O_READDATA(rdat), .O_WAITREQUEST(wreq),
    .I_SRC_EVENT(src), .I_TRAP(trap), .I_RESET_EVENT(rst_ev), .I_SW_TRAP(sw),
    .I_SW_TRAP_NUM(swn), .I_CPU_PRIO(prio), .I_SERVICE_DONE(done), .O_SHARED_VEC(vec),
    .O_BRANCH(br), .O_BRANCH_INFO(binfo), .O_BLOCK_STD(blk), .O_IRQ(irq));
  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  // request stands from just after an edge until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= {16'h0000, d};
    wr <= w;
    rd <= !w;
    forever begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    q = rdat[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wrt(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdr(input logic [3:0] a, output logic [15:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask
  task automatic t_regs;
    logic [15:0] q;
    for (int v = 0; v < 4; v++) begin
      rdr(4'(v), q);
      chk(q, SEL_RESET);
      wrt(4'(v), 16'hFF00);
      rdr(4'(v), q);
      chk(q, {ROUTE_ALL[v*8+:8], 8'h00});
      wrt(4'(v), 16'h0000);
    end
    rdr(4'hB, q);
    chk(q, 16'h0000);
  endtask
  task automatic t_vec;
    logic [15:0] q;
    logic [7:0] r;
    for (int v = 0; v < 4; v++) begin
      r = ROUTE_ALL[v*8+:8];
      far.pulse(8'hFF, 9'h000, 1'b0, 1'b0, 7'h00, 4'h0, 1'b0);
      repeat (3) @(posedge clk);
      rdr(4'(v), q);
      chk(q[7:0] & r, r);
      chk(vec[v], 1'b0);
      wrt(4'(v), {r, 8'hFF});
      repeat (3) @(posedge clk);
      chk(vec[v], 1'b1);
      wrt(4'(v), {r, 8'h00});
      repeat (3) @(posedge clk);
      chk(vec[v], 1'b0);
      rdr(4'(v), q);
      chk(q[7:0] & r, 8'h00);
      wrt(4'(v), 16'h0000);
    end
    rdr(ADR_IRQ_STAT, q);
    chk(q[3:0], 4'hF);
    chk(irq, 1'b0);
    wrt(ADR_IRQ_MASK, 16'h0001);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wrt(ADR_IRQ_STAT, 16'h001F);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wrt(ADR_IRQ_MASK, 16'h0000);
  endtask
  task automatic t_trap(input logic [8:0] t, input logic r, input logic s,
                        input logic [6:0] n, input logic [3:0] p, input xirq_branch_t e,
                        input logic [1:0] c, input logic [15:0] f);
    logic [15:0] q;
    far.pulse(8'h00, t, r, s, n, p, 1'b0);
    @(posedge clk);
    chk(br, 1'b1);
    repeat (2) @(posedge clk);
    chk(br, 1'b0);
    chk(binfo, e);
    chk(blk, !s);
    rdr(ADR_TRAP_STATE, q);
    chk(q[1:0], c);
    rdr(ADR_TRAP_FLAG, q);
    chk(q & f, f);
    wrt(ADR_TRAP_FLAG, 16'h0000);
    rdr(ADR_IRQ_STAT, q);
    chk(q[4], !s);
    wrt(ADR_IRQ_STAT, 16'h001F);
    far.pulse(8'h00, 9'h000, 1'b0, 1'b0, n, p, 1'b1);
    repeat (3) @(posedge clk);
    chk(blk, 1'b0);
  endtask
  task automatic t_traps;
    int bpos[6] = '{0, 6, 1, 2, 3, 7};
    t_trap(9'h000, 1'b1, 1'b0, 7'h00, 4'h3, {VEC_RESET, TN_RESET, PRIO_MAX}, EXC_RESET,
           16'h0000);
    t_trap(9'h100, 1'b0, 1'b0, 7'h00, 4'h3, {VEC_NMI, TN_NMI, PRIO_MAX}, EXC_CLASS_A,
           16'h8000);
    t_trap(9'h080, 1'b0, 1'b0, 7'h00, 4'h3, {VEC_STKOV, TN_STKOV, PRIO_MAX}, EXC_CLASS_A,
           16'h4000);
    t_trap(9'h040, 1'b0, 1'b0, 7'h00, 4'h3, {VEC_STKUN, TN_STKUN, PRIO_MAX}, EXC_CLASS_A,
           16'h2000);
    for (int i = 0; i < 6; i++) begin
      t_trap(9'(1 << (5 - i)), 1'b0, 1'b0, 7'h00, 4'h3, {VEC_CLASS_B, TN_CLASS_B, PRIO_MAX},
             EXC_CLASS_B, 16'(1 << bpos[i]));
    end
    t_trap(9'h000, 1'b0, 1'b1, 7'h7F, 4'h5, {24'h0001FC, 7'h7F, 4'h5}, EXC_NONE,
           16'h0000);
    t_trap(9'h000, 1'b0, 1'b1, 7'h15, 4'h9, {24'h000054, 7'h15, 4'h9}, EXC_NONE,
           16'h0000);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_vec;
    t_traps;
    test_done;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done;
  end
endmodule // tb_xbus_irq_mux_and_traps
